// >>> design/hscmp_pkg.sv
// package: constants, types and decode functions of the counter compare unit
package hscmp_pkg;
	localparam int N_SW   = 11;
	localparam int N_SWC  = 6;
	localparam int N_CH   = 4;
	localparam int N_HWC  = 8;
	localparam int LIM_SW = 6;
	localparam int LIM_HW = 4;
	localparam int LIM_SM = 4;
	localparam int LIM_MD = 6;
	localparam int GRP_LO = 3;
	localparam int GRP_HI = 8;
	localparam int CLK_NS = 100;
	localparam int SW_PER_NS  = 100000;
	localparam int GRP_PER_NS = 50000;
	localparam logic [9:0] SW_HOLD  = 10'((SW_PER_NS + CLK_NS - 1) / CLK_NS);
	localparam logic [9:0] GRP_HOLD = 10'((GRP_PER_NS + CLK_NS - 1) / CLK_NS);
	// irq number minus one for software counters 232..242, index 0 last
	localparam logic [32:0] SW_IRQ_MAP = {3'h7, 3'h6, 3'h5, 3'h4, 3'h3, 3'h2,
		3'h1, 3'h0, 3'h6, 3'h4, 3'h0};
	localparam logic [11:0] OFF_CTRL   = 12'h000;
	localparam logic [11:0] OFF_STAT   = 12'h004;
	localparam logic [11:0] OFF_DIR    = 12'h008;
	localparam logic [11:0] OFF_IRQDIS = 12'h00C;
	localparam logic [11:0] OFF_MODE   = 12'h010;
	localparam logic [11:0] OFF_ASSIGN = 12'h014;
	localparam logic [11:0] OFF_TGT    = 12'h018;
	localparam logic [11:0] OFF_SWCCFG = 12'h020;
	localparam logic [11:0] OFF_SWCVAL = 12'h040;
	localparam logic [11:0] OFF_HWCCFG = 12'h060;
	localparam logic [11:0] OFF_HWCVAL = 12'h080;
	localparam logic [11:0] OFF_SWCNT  = 12'h100;
	localparam logic [11:0] OFF_HWCNT  = 12'h140;
	localparam logic [1:0] RESP_OK  = 2'h0;
	localparam logic [1:0] RESP_ERR = 2'h2;
	localparam logic [31:0] RST_WORD = 32'h0000_0000;
	typedef enum logic [1:0] {ACT_OFF = 2'b00, ACT_SET = 2'b01, ACT_RST = 2'b10, ACT_IRQ = 2'b11} act_t;
	typedef enum logic [1:0] {MODE_PDIR = 2'b00, MODE_CW = 2'b01, MODE_QUAD = 2'b10} mode_t;
	typedef enum logic [1:0] {VAR_FULL = 2'b00, VAR_SMALL = 2'b01, VAR_MID = 2'b10} variant_t;
	typedef struct packed {
		logic [2:0] tgt;
		logic [7:0] cnt;
		act_t       act;
	} cmp_cfg_t;
	typedef struct packed {
		logic step;
		logic down;
	} step_t;

	// channel of a hardware counter number; bit 2 flags a known number
	function automatic logic [2:0] chan_of(input logic [7:0] n);
		case (n)
			8'hF1, 8'hF6, 8'hFB: chan_of = 3'h4;
			8'hF2, 8'hF7, 8'hFC: chan_of = 3'h5;
			8'hF3, 8'hF5, 8'hF8, 8'hFD: chan_of = 3'h6;
			8'hF4, 8'hF9, 8'hFA, 8'hFE: chan_of = 3'h7;
			default: chan_of = 3'h0;
		endcase
	endfunction

	function automatic logic in_grp_a(input logic [7:0] n);
		in_grp_a = (n == 8'hF3) || (n >= 8'hF5 && n <= 8'hF8) || n == 8'hFB || n == 8'hFC;
	endfunction

	function automatic logic in_grp_b(input logic [7:0] n);
		in_grp_b = n == 8'hF4 || n == 8'hF9 || n == 8'hFA || n == 8'hFD || n == 8'hFE;
	endfunction
endpackage

// >>> design/step_decode.sv
// pulse decoder of one hardware counter channel
`timescale 1ns/1ns
`default_nettype none
module step_decode (
	input  wire logic           clk,
	input  wire logic           rst_n,
	input  wire logic           a,
	input  wire logic           b,
	input  wire hscmp_pkg::mode_t mode,
	output hscmp_pkg::step_t    ev
);
	logic             a_q;
	logic             b_q;
	hscmp_pkg::step_t ev_d;

	always_comb
	begin
		ev_d = '0;
		case (mode)
			hscmp_pkg::MODE_PDIR:
			begin
				ev_d.step = a & ~a_q;
				ev_d.down = b;
			end
			hscmp_pkg::MODE_CW:
			begin
				// both edges at once cancel out
				ev_d.step = (a & ~a_q) ^ (b & ~b_q);
				ev_d.down = b & ~b_q;
			end
			hscmp_pkg::MODE_QUAD:
			begin
				// every edge of both phases counts; a double change is noise
				ev_d.step = (a ^ a_q) ^ (b ^ b_q);
				ev_d.down = (a ^ a_q) ? (a == b) : (a != b);
			end
			default: ev_d = '0;
		endcase
	end

	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			a_q <= 1'b0;
			b_q <= 1'b0;
			ev  <= '0;
		end
		else
		begin
			a_q <= a;
			b_q <= b;
			ev  <= ev_d;
		end
	end
endmodule // step_decode
`default_nettype wire

// >>> design/axil_port.sv
// axi4-lite slave handshake for the register file
`timescale 1ns/1ns
`default_nettype none
module axil_port (
	input  wire logic        clk,
	input  wire logic        rst_n,
	input  wire logic [11:0] awaddr,
	input  wire logic        awvalid,
	output logic             awready,
	input  wire logic [31:0] wdata,
	input  wire logic [3:0]  wstrb,
	input  wire logic        wvalid,
	output logic             wready,
	output logic [1:0]       bresp,
	output logic             bvalid,
	input  wire logic        bready,
	input  wire logic [11:0] araddr,
	input  wire logic        arvalid,
	output logic             arready,
	output logic [31:0]      rdata,
	output logic [1:0]       rresp,
	output logic             rvalid,
	input  wire logic        rready,
	output logic             wr_en,
	output logic [11:0]      wr_addr,
	output logic [31:0]      wr_data,
	output logic [3:0]       wr_strb,
	input  wire logic        wr_ok,
	output logic [11:0]      rd_addr,
	input  wire logic [31:0] rd_data,
	input  wire logic        rd_ok
);
	logic aw_q;
	logic w_q;

	// address and data are held until both are in, in either order
	assign awready = ~aw_q & ~bvalid;
	assign wready  = ~w_q & ~bvalid;
	assign wr_en   = aw_q & w_q & ~bvalid;
	assign arready = ~rvalid;
	assign rd_addr = araddr;

	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			aw_q    <= 1'b0;
			w_q     <= 1'b0;
			wr_addr <= '0;
			wr_data <= '0;
			wr_strb <= '0;
			bvalid  <= 1'b0;
			bresp   <= hscmp_pkg::RESP_OK;
		end
		else
		begin
			if (awvalid && awready)
			begin
				aw_q    <= 1'b1;
				wr_addr <= awaddr;
			end
			if (wvalid && wready)
			begin
				w_q     <= 1'b1;
				wr_data <= wdata;
				wr_strb <= wstrb;
			end
			if (wr_en)
			begin
				aw_q   <= 1'b0;
				w_q    <= 1'b0;
				bvalid <= 1'b1;
				bresp  <= wr_ok ? hscmp_pkg::RESP_OK : hscmp_pkg::RESP_ERR;
			end
			else if (bready)
				bvalid <= 1'b0;
		end
	end

	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			rvalid <= 1'b0;
			rdata  <= '0;
			rresp  <= hscmp_pkg::RESP_OK;
		end
		else if (arvalid && arready)
		begin
			rvalid <= 1'b1;
			rdata  <= rd_data;
			rresp  <= rd_ok ? hscmp_pkg::RESP_OK : hscmp_pkg::RESP_ERR;
		end
		else if (rready)
			rvalid <= 1'b0;
	end
endmodule // axil_port
`default_nettype wire

// >>> design/hs_counter_compare_unit.sv
// high-speed counters with software and hardware compare-and-act logic
//
// Added by the designer: the register offsets and the AXI4-Lite slave port.
`timescale 1ns/1ns
`default_nettype none
// Overview of operation
// - six software comparators, counters 232..242, interrupts
// - over six software set/reset uses flags error
// - fixed counter to match interrupt map
// - groups A and B, four comparators each
// - over four uses per group flags error
// - interrupt once only; 1-4 A, 5-8 B
// - fixed counter numbers per comparator group
// - 245 compares on 243 when 243 enabled
// - software match on count equal value
// - hardware match at value+1 up, value-1 down
// - set on count up, reset on down
// - interrupt pulse at once on match
// - only counted pulses trigger, not writes
// - quadrature counts every edge of both phases
// - 10 kHz per counter, 20 kHz shared
// - three counter numbers share channels 0 and 1, four share channels 2 and 3
// - one counter number per channel
// - pulse/dir, cw/ccw, quadrature modes
// - small variant: at most four set/reset uses
// - mid variant: six incl. zone uses
// - set output stays on until reset
// - direction bit: clear up, set down
// - disable bits mask interrupts 1..6
module hs_counter_compare_unit (
	input  wire logic        clk,
	input  wire logic        rst_n,
	input  wire logic [11:0] awaddr,
	input  wire logic        awvalid,
	output logic             awready,
	input  wire logic [31:0] wdata,
	input  wire logic [3:0]  wstrb,
	input  wire logic        wvalid,
	output logic             wready,
	output logic [1:0]       bresp,
	output logic             bvalid,
	input  wire logic        bready,
	input  wire logic [11:0] araddr,
	input  wire logic        arvalid,
	output logic             arready,
	output logic [31:0]      rdata,
	output logic [1:0]       rresp,
	output logic             rvalid,
	input  wire logic        rready,
	input  wire logic [10:0] sw_pulse,
	input  wire logic [3:0]  hw_a,
	input  wire logic [3:0]  hw_b,
	output logic [7:0]       compare_target_bit,
	output logic [7:0]       match_irq,
	output logic             cfg_error
);
	logic                  wr_en;
	logic [11:0]           wr_addr;
	logic [31:0]           wr_data;
	logic [3:0]            wr_strb;
	logic                  wr_ok;
	logic [11:0]           rd_addr;
	logic [31:0]           rd_data;
	logic                  rd_ok;
	logic [31:0]           sw_cnt_q [hscmp_pkg::N_SW];
	logic [31:0]           sw_cnt_d [hscmp_pkg::N_SW];
	logic [31:0]           hw_cnt_q [hscmp_pkg::N_CH];
	logic [31:0]           hw_cnt_d [hscmp_pkg::N_CH];
	logic [9:0]            hold_q [hscmp_pkg::N_SW];
	logic [9:0]            grp_hold_q;
	logic [10:0]           sw_in_q;
	logic [10:0]           sw_acc;
	logic [10:0]           sw_wr;
	logic [3:0]            hw_wr;
	logic [10:0]           count_direction_bit_q;
	logic [5:0]            match_irq_disable_bits_q;
	logic [1:0]            variant_q;
	logic [3:0]            zone_uses_q;
	logic [7:0]            mode_q;
	logic [31:0]           assign_q;
	hscmp_pkg::cmp_cfg_t   swc_cfg_q [hscmp_pkg::N_SWC];
	logic [31:0]           swc_val_q [hscmp_pkg::N_SWC];
	hscmp_pkg::cmp_cfg_t   hwc_cfg_q [hscmp_pkg::N_HWC];
	logic [31:0]           hwc_val_q [hscmp_pkg::N_HWC];
	hscmp_pkg::step_t      hw_ev [hscmp_pkg::N_CH];
	logic [7:0]            set_v;
	logic [7:0]            rst_v;
	logic [7:0]            irq_v;
	logic                  err_d;

	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] st);
		merge = old;
		for (int k = 0; k < 4; k++)
			if (st[k])
				merge[8*k+:8] = nw[8*k+:8];
	endfunction

	function automatic logic hit_reg(input logic [11:0] a, input logic [11:0] base, input int n);
		hit_reg = (a[11:5] == base[11:5]) && (int'(a[4:2]) < n);
	endfunction

	function automatic logic mapped(input logic [11:0] a);
		mapped = (a[11:5] == 7'h00 && a[4:2] <= 3'h6) ||
			hit_reg(a, hscmp_pkg::OFF_SWCCFG, hscmp_pkg::N_SWC) ||
			hit_reg(a, hscmp_pkg::OFF_SWCVAL, hscmp_pkg::N_SWC) ||
			hit_reg(a, hscmp_pkg::OFF_HWCCFG, hscmp_pkg::N_HWC) ||
			hit_reg(a, hscmp_pkg::OFF_HWCVAL, hscmp_pkg::N_HWC) ||
			(a[11:6] == hscmp_pkg::OFF_SWCNT[11:6] && int'(a[5:2]) < hscmp_pkg::N_SW) ||
			hit_reg(a, hscmp_pkg::OFF_HWCNT, hscmp_pkg::N_CH);
		mapped = mapped && a[1:0] == 2'h0;
	endfunction

	axil_port u_bus (
		.clk     (clk),
		.rst_n   (rst_n),
		.awaddr  (awaddr),
		.awvalid (awvalid),
		.awready (awready),
		.wdata   (wdata),
		.wstrb   (wstrb),
		.wvalid  (wvalid),
		.wready  (wready),
		.bresp   (bresp),
		.bvalid  (bvalid),
		.bready  (bready),
		.araddr  (araddr),
		.arvalid (arvalid),
		.arready (arready),
		.rdata   (rdata),
		.rresp   (rresp),
		.rvalid  (rvalid),
		.rready  (rready),
		.wr_en   (wr_en),
		.wr_addr (wr_addr),
		.wr_data (wr_data),
		.wr_strb (wr_strb),
		.wr_ok   (wr_ok),
		.rd_addr (rd_addr),
		.rd_data (rd_data),
		.rd_ok   (rd_ok)
	);

	assign wr_ok = mapped(wr_addr);
	assign rd_ok = mapped(rd_addr);

	for (genvar c = 0; c < hscmp_pkg::N_CH; c++)
	begin : g_ch
		step_decode u_dec (
			.clk   (clk),
			.rst_n (rst_n),
			.a     (hw_a[c]),
			.b     (hw_b[c]),
			.mode  (hscmp_pkg::mode_t'(mode_q[2*c+:2])),
			.ev    (hw_ev[c])
		);
	end

	// software counters: edge accept with per-counter and shared holdoff
	always_comb
	begin
		logic taken;
		taken = 1'b0;
		for (int i = 0; i < hscmp_pkg::N_SW; i++)
		begin
			sw_acc[i] = sw_pulse[i] & ~sw_in_q[i] & (hold_q[i] == '0);
			if (i >= hscmp_pkg::GRP_LO && i <= hscmp_pkg::GRP_HI)
			begin
				if (grp_hold_q != '0 || taken)
					sw_acc[i] = 1'b0;
				else if (sw_acc[i])
					taken = 1'b1;
			end
			sw_wr[i] = wr_en && wr_addr == hscmp_pkg::OFF_SWCNT + 12'(4 * i);
			sw_cnt_d[i] = sw_cnt_q[i];
			if (sw_acc[i])
				sw_cnt_d[i] = count_direction_bit_q[i] ? sw_cnt_q[i] - 32'h1 : sw_cnt_q[i] + 32'h1;
		end
		for (int c = 0; c < hscmp_pkg::N_CH; c++)
		begin
			hw_wr[c] = wr_en && wr_addr == hscmp_pkg::OFF_HWCNT + 12'(4 * c);
			hw_cnt_d[c] = hw_cnt_q[c];
			if (hw_ev[c].step)
				hw_cnt_d[c] = hw_ev[c].down ? hw_cnt_q[c] - 32'h1 : hw_cnt_q[c] + 32'h1;
		end
	end

	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			sw_in_q    <= '0;
			grp_hold_q <= '0;
			for (int i = 0; i < hscmp_pkg::N_SW; i++)
				hold_q[i] <= '0;
		end
		else
		begin
			sw_in_q    <= sw_pulse;
			grp_hold_q <= (|sw_acc[hscmp_pkg::GRP_HI:hscmp_pkg::GRP_LO]) ? hscmp_pkg::GRP_HOLD - 10'h1 :
				(grp_hold_q != '0) ? grp_hold_q - 10'h1 : '0;
			for (int i = 0; i < hscmp_pkg::N_SW; i++)
				hold_q[i] <= sw_acc[i] ? hscmp_pkg::SW_HOLD - 10'h1 : (hold_q[i] != '0) ? hold_q[i] - 10'h1 : '0;
		end
	end

	// a direct write loads the count and suppresses that cycle's step
	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			for (int i = 0; i < hscmp_pkg::N_SW; i++)
				sw_cnt_q[i] <= hscmp_pkg::RST_WORD;
			for (int c = 0; c < hscmp_pkg::N_CH; c++)
				hw_cnt_q[c] <= hscmp_pkg::RST_WORD;
		end
		else
		begin
			for (int i = 0; i < hscmp_pkg::N_SW; i++)
				sw_cnt_q[i] <= sw_wr[i] ? merge(sw_cnt_q[i], wr_data, wr_strb) : sw_cnt_d[i];
			for (int c = 0; c < hscmp_pkg::N_CH; c++)
				hw_cnt_q[c] <= hw_wr[c] ? merge(hw_cnt_q[c], wr_data, wr_strb) : hw_cnt_d[c];
		end
	end

	// configuration registers
	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			count_direction_bit_q    <= '0;
			match_irq_disable_bits_q <= '0;
			variant_q                <= hscmp_pkg::VAR_FULL;
			zone_uses_q              <= '0;
			mode_q                   <= '0;
			assign_q                 <= hscmp_pkg::RST_WORD;
			for (int k = 0; k < hscmp_pkg::N_SWC; k++)
			begin
				swc_cfg_q[k] <= '0;
				swc_val_q[k] <= hscmp_pkg::RST_WORD;
			end
			for (int k = 0; k < hscmp_pkg::N_HWC; k++)
			begin
				hwc_cfg_q[k] <= '0;
				hwc_val_q[k] <= hscmp_pkg::RST_WORD;
			end
		end
		else if (wr_en)
		begin
			case (wr_addr)
				hscmp_pkg::OFF_CTRL:
				begin
					variant_q   <= 2'(merge(32'(variant_q), wr_data, wr_strb));
					zone_uses_q <= 4'(merge(32'(zone_uses_q) << 4, wr_data, wr_strb) >> 4);
				end
				hscmp_pkg::OFF_DIR: count_direction_bit_q <= 11'(merge(32'(count_direction_bit_q), wr_data, wr_strb));
				hscmp_pkg::OFF_IRQDIS: match_irq_disable_bits_q <= 6'(merge(32'(match_irq_disable_bits_q), wr_data, wr_strb));
				hscmp_pkg::OFF_MODE: mode_q <= 8'(merge(32'(mode_q), wr_data, wr_strb));
				hscmp_pkg::OFF_ASSIGN: assign_q <= merge(assign_q, wr_data, wr_strb);
				default: ;
			endcase
			for (int k = 0; k < hscmp_pkg::N_SWC; k++)
			begin
				if (wr_addr == hscmp_pkg::OFF_SWCCFG + 12'(4 * k))
					swc_cfg_q[k] <= hscmp_pkg::cmp_cfg_t'(13'(merge(32'(swc_cfg_q[k]), wr_data, wr_strb)));
				if (wr_addr == hscmp_pkg::OFF_SWCVAL + 12'(4 * k))
					swc_val_q[k] <= merge(swc_val_q[k], wr_data, wr_strb);
			end
			for (int k = 0; k < hscmp_pkg::N_HWC; k++)
			begin
				if (wr_addr == hscmp_pkg::OFF_HWCCFG + 12'(4 * k))
					hwc_cfg_q[k] <= hscmp_pkg::cmp_cfg_t'(13'(merge(32'(hwc_cfg_q[k]), wr_data, wr_strb)));
				if (wr_addr == hscmp_pkg::OFF_HWCVAL + 12'(4 * k))
					hwc_val_q[k] <= merge(hwc_val_q[k], wr_data, wr_strb);
			end
		end
	end

	// program check: a bad set-up halts every comparator
	always_comb
	begin
		int       n_sw;
		int       n_a;
		int       n_b;
		logic [7:0] used;
		logic [2:0] ch;
		logic [7:0] num;
		ch    = '0;
		num   = '0;
		n_sw  = 0;
		n_a   = 0;
		n_b   = 0;
		used  = '0;
		err_d = 1'b0;
		for (int k = 0; k < hscmp_pkg::N_SWC; k++)
		begin
			if (swc_cfg_q[k].act == hscmp_pkg::ACT_SET || swc_cfg_q[k].act == hscmp_pkg::ACT_RST)
				n_sw++;
			if (swc_cfg_q[k].act != hscmp_pkg::ACT_OFF && int'(swc_cfg_q[k].cnt) >= hscmp_pkg::N_SW)
				err_d = 1'b1;
		end
		for (int c = 0; c < hscmp_pkg::N_CH; c++)
		begin
			ch = hscmp_pkg::chan_of(assign_q[8*c+:8]);
			if (assign_q[8*c+:8] != '0 && ch != {1'b1, 2'(c)})
				err_d = 1'b1;
		end
		for (int k = 0; k < hscmp_pkg::N_HWC; k++)
		begin
			num = hwc_cfg_q[k].cnt;
			ch  = hscmp_pkg::chan_of(num);
			if (hwc_cfg_q[k].act == hscmp_pkg::ACT_SET || hwc_cfg_q[k].act == hscmp_pkg::ACT_RST)
			begin
				if (k < 4)
					n_a++;
				else
					n_b++;
			end
			if (hwc_cfg_q[k].act != hscmp_pkg::ACT_OFF)
			begin
				if (k < 4 ? !hscmp_pkg::in_grp_a(num) : !hscmp_pkg::in_grp_b(num))
					err_d = 1'b1;
				if (!ch[2] || (assign_q[8*ch[1:0]+:8] != num &&
					!(num == 8'hF5 && assign_q[23:16] == 8'hF3)))
					err_d = 1'b1;
			end
			if (hwc_cfg_q[k].act == hscmp_pkg::ACT_IRQ)
			begin
				if ((k < 4) == hwc_cfg_q[k].tgt[2] || used[hwc_cfg_q[k].tgt])
					err_d = 1'b1;
				used[hwc_cfg_q[k].tgt] = 1'b1;
			end
		end
		if (n_sw > hscmp_pkg::LIM_SW)
			err_d = 1'b1;
		if (n_a > hscmp_pkg::LIM_HW || n_b > hscmp_pkg::LIM_HW)
			err_d = 1'b1;
		if (variant_q == hscmp_pkg::VAR_SMALL && n_sw + n_a + n_b > hscmp_pkg::LIM_SM)
			err_d = 1'b1;
		if (variant_q == hscmp_pkg::VAR_MID && n_sw + n_a + n_b + int'(zone_uses_q) > hscmp_pkg::LIM_MD)
			err_d = 1'b1;
	end

	// compare on counted steps only
	always_comb
	begin
		logic [3:0]  ix;
		logic [1:0]  ch;
		logic        ev;
		logic        dn;
		logic        hit;
		logic [31:0] ref_v;
		ix    = '0;
		ch    = '0;
		ev    = 1'b0;
		dn    = 1'b0;
		hit   = 1'b0;
		ref_v = '0;
		set_v = '0;
		rst_v = '0;
		irq_v = '0;
		for (int k = 0; k < hscmp_pkg::N_SWC; k++)
		begin
			ix  = swc_cfg_q[k].cnt[3:0];
			ev  = 1'b0;
			dn  = 1'b0;
			hit = 1'b0;
			if (int'(ix) < hscmp_pkg::N_SW && swc_cfg_q[k].cnt[7:4] == '0)
			begin
				ev  = sw_acc[ix] & ~sw_wr[ix];
				dn  = count_direction_bit_q[ix];
				hit = ev && sw_cnt_d[ix] == swc_val_q[k];
			end
			case (swc_cfg_q[k].act)
				hscmp_pkg::ACT_SET: set_v[swc_cfg_q[k].tgt] |= hit & ~dn;
				hscmp_pkg::ACT_RST: rst_v[swc_cfg_q[k].tgt] |= hit & dn;
				hscmp_pkg::ACT_IRQ: irq_v[hscmp_pkg::SW_IRQ_MAP[3*ix+:3]] |= hit;
				default: ;
			endcase
		end
		for (int k = 0; k < hscmp_pkg::N_HWC; k++)
		begin
			ch    = 2'(hscmp_pkg::chan_of(hwc_cfg_q[k].cnt));
			ev    = hw_ev[ch].step & ~hw_wr[ch];
			dn    = hw_ev[ch].down;
			ref_v = dn ? hwc_val_q[k] - 32'h1 : hwc_val_q[k] + 32'h1;
			hit   = ev && hw_cnt_d[ch] == ref_v;
			case (hwc_cfg_q[k].act)
				hscmp_pkg::ACT_SET: set_v[hwc_cfg_q[k].tgt] |= hit & ~dn;
				hscmp_pkg::ACT_RST: rst_v[hwc_cfg_q[k].tgt] |= hit & dn;
				hscmp_pkg::ACT_IRQ: irq_v[hwc_cfg_q[k].tgt] |= hit;
				default: ;
			endcase
		end
	end

	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			compare_target_bit <= '0;
			match_irq          <= '0;
			cfg_error          <= 1'b0;
		end
		else
		begin
			cfg_error <= err_d;
			// hardware set beats a bus clear; a reset match beats both
			compare_target_bit <= ((wr_en && wr_addr == hscmp_pkg::OFF_TGT ?
				8'(merge(32'(compare_target_bit), wr_data, wr_strb)) : compare_target_bit) |
				(cfg_error ? 8'h00 : set_v)) & ~(cfg_error ? 8'h00 : rst_v);
			match_irq <= cfg_error ? 8'h00 : irq_v & ~{2'b00, match_irq_disable_bits_q};
		end
	end

	always_comb
	begin
		rd_data = '0;
		case (rd_addr)
			hscmp_pkg::OFF_CTRL: rd_data = {24'h0, zone_uses_q, 2'b00, variant_q};
			hscmp_pkg::OFF_STAT: rd_data = {16'h0, compare_target_bit, 7'h0, cfg_error};
			hscmp_pkg::OFF_DIR: rd_data = {21'h0, count_direction_bit_q};
			hscmp_pkg::OFF_IRQDIS: rd_data = {26'h0, match_irq_disable_bits_q};
			hscmp_pkg::OFF_MODE: rd_data = {24'h0, mode_q};
			hscmp_pkg::OFF_ASSIGN: rd_data = assign_q;
			hscmp_pkg::OFF_TGT: rd_data = {24'h0, compare_target_bit};
			default:
			begin
				for (int k = 0; k < hscmp_pkg::N_SWC; k++)
				begin
					if (rd_addr == hscmp_pkg::OFF_SWCCFG + 12'(4 * k))
						rd_data = {19'h0, swc_cfg_q[k]};
					if (rd_addr == hscmp_pkg::OFF_SWCVAL + 12'(4 * k))
						rd_data = swc_val_q[k];
				end
				for (int k = 0; k < hscmp_pkg::N_HWC; k++)
				begin
					if (rd_addr == hscmp_pkg::OFF_HWCCFG + 12'(4 * k))
						rd_data = {19'h0, hwc_cfg_q[k]};
					if (rd_addr == hscmp_pkg::OFF_HWCVAL + 12'(4 * k))
						rd_data = hwc_val_q[k];
				end
				for (int i = 0; i < hscmp_pkg::N_SW; i++)
					if (rd_addr == hscmp_pkg::OFF_SWCNT + 12'(4 * i))
						rd_data = sw_cnt_q[i];
				for (int c = 0; c < hscmp_pkg::N_CH; c++)
					if (rd_addr == hscmp_pkg::OFF_HWCNT + 12'(4 * c))
						rd_data = hw_cnt_q[c];
			end
		endcase
	end
endmodule // hs_counter_compare_unit
`default_nettype wire

// >>> test/hscmp_asserts.sv
// checker of the counter compare unit port behaviour
`timescale 1ns/1ns
`default_nettype none
module hscmp_asserts (
	input wire logic        clk,
	input wire logic        rst_n,
	input wire logic        awvalid,
	input wire logic        awready,
	input wire logic        wvalid,
	input wire logic        wready,
	input wire logic [1:0]  bresp,
	input wire logic        bvalid,
	input wire logic        bready,
	input wire logic        arvalid,
	input wire logic        arready,
	input wire logic [31:0] rdata,
	input wire logic        rvalid,
	input wire logic        rready,
	input wire logic [7:0]  compare_target_bit,
	input wire logic [7:0]  match_irq,
	input wire logic        cfg_error
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	sequence s_wtake;
		awvalid && awready && wvalid && wready;
	endsequence
	sequence s_rtake;
		arvalid && arready;
	endsequence
	a_wr_answer: assert property (s_wtake |-> ##[1:2] bvalid) else $error("write answer late");
	a_rd_answer: assert property (s_rtake |=> rvalid) else $error("read answer late");
	a_b_stand: assert property (bvalid && !bready |=> bvalid && $stable(bresp)) else $error("bresp dropped");
	a_r_stand: assert property (rvalid && !rready |=> rvalid && $stable(rdata)) else $error("rdata dropped");
	a_w_refuse: assert property (bvalid |-> !awready && !wready) else $error("write taken early");
	a_ar_refuse: assert property (rvalid |-> !arready) else $error("read taken early");
	// pulses must not merge, or software would count one match twice
	a_irq_pulse: assert property (|match_irq |=> (match_irq & $past(match_irq)) == 8'h00)
		else $error("irq longer than one cycle");
	a_boot_quiet: assert property ($rose(rst_n) |-> match_irq == 8'h00 && compare_target_bit == 8'h00
		&& !bvalid && !rvalid) else $error("outputs live after reset");
	a_err_gate: assert property (cfg_error [*4] |-> match_irq == 8'h00) else $error("irq despite bad program");
endmodule // hscmp_asserts
bind hs_counter_compare_unit hscmp_asserts hscmp_asserts_i (.*);
`default_nettype wire

// >>> test/pulse_src.sv
// pulse source model: counter pulses and one quadrature channel
`timescale 1ns/1ns
`default_nettype none
module pulse_src (
	input  wire logic        clk,
	input  wire logic [10:0] sreq,
	input  wire logic        qreq,
	output logic [10:0]      sw_pulse,
	output logic [3:0]       hw_a,
	output logic [3:0]       hw_b
);
	logic [10:0] h1 = 11'h000;
	logic [10:0] h2 = 11'h000;
	logic [4:0]  ph = 5'h00;
	logic [1:0]  g;
	// unused lines rest low, as a pull-down would leave them
	always_ff @(posedge clk)
	begin
		h1 <= sreq;
		h2 <= h1;
		sw_pulse <= sreq | h1 | h2;
		ph <= (qreq || ph != 5'h00) ? ph + 5'h01 : 5'h00;
	end
	assign g = ph[4:3];
	assign hw_a = {3'h0, g[0] ^ g[1]};
	assign hw_b = {3'h0, g[1]};
endmodule // pulse_src
`default_nettype wire

// >>> test/tb_hs_counter_compare_unit.sv
// self-checking bench of the counter compare unit
`timescale 1ns/1ns
`default_nettype none
module tb_hs_counter_compare_unit;
	logic clk = 0, rst_n = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0, qreq = 0;
	logic [11:0] awaddr = 0, araddr = 0;
	logic [31:0] wdata = 0, rdata, rv, x, seed = 32'd52707;
	logic [3:0]  wstrb = 4'hF, hw_a, hw_b;
	logic        awready, wready, bvalid, arready, rvalid, cfg_error;
	logic [1:0]  bresp, rresp, rs;
	logic [10:0] sw_pulse, sreq = 0;
	logic [7:0]  compare_target_bit, match_irq, mt = 0, seen, ex;
	int n_fail = 0, checks_done = 0, dis = 0, mc[11], md[11], ca[6], cc[6], ct[6], cv[6];
	int im[11] = '{0, 4, 6, 0, 1, 2, 3, 4, 5, 6, 7};
	always #50 clk = ~clk;
	hs_counter_compare_unit hs_counter_compare_unit_i (.*);
	pulse_src pulse_src_i (.*);
	function automatic logic [31:0] xs();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	task automatic end_sim();
		$display("checks %0d fails %0d", checks_done, n_fail);
		if (n_fail == 0 && checks_done > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	task automatic chk(string s, logic [31:0] e, logic [31:0] g);
		checks_done++;
		if (g !== e)
		begin
			$display("unexpected %s exp %h got %h", s, e, g);
			n_fail++;
		end
	endtask
	task automatic tmo(int n);
		if (n >= 99)
		begin
			n_fail++;
			end_sim();
		end
	endtask
	task automatic wr(logic [11:0] a, logic [31:0] d);
		int n = 0;
		logic pa = 1, pw = 1;
		awaddr <= a;
		wdata <= d;
		awvalid <= 1;
		wvalid <= 1;
		bready <= 1;
		do
		begin
			@(posedge clk);
			n++;
			if (pa && awready) begin awvalid <= 0; pa = 0; end
			if (pw && wready) begin wvalid <= 0; pw = 0; end
		end while (!bvalid && n < 99);
		rs = bresp;
		bready <= 0;
		tmo(n);
		@(posedge clk);
	endtask
	task automatic rd(logic [11:0] a);
		int n = 0;
		araddr <= a;
		arvalid <= 1;
		rready <= 1;
		do
		begin
			@(posedge clk);
			n++;
			if (arready) arvalid <= 0;
		end while (!rvalid && n < 99);
		rv = rdata;
		rs = rresp;
		rready <= 0;
		tmo(n);
		@(posedge clk);
	endtask
	task automatic sw_cfg(int k, int a, int c, int t, int v);
		wr(hscmp_pkg::OFF_SWCCFG + 12'(4 * k), 32'(a | c << 2 | t << 10));
		wr(hscmp_pkg::OFF_SWCVAL + 12'(4 * k), 32'(v));
		ca[k] = a; cc[k] = c; ct[k] = t; cv[k] = v;
	endtask
	// one counted pulse, then the model predicts irq and target bits
	task automatic pulse(int i);
		sreq <= 11'(1 << i);
		@(posedge clk);
		sreq <= 0;
		seen = 0;
		repeat (12)
		begin
			@(posedge clk);
			seen |= match_irq;
		end
		mc[i] += md[i] ? -1 : 1;
		ex = 0;
		for (int k = 0; k < 6; k++)
			if (ca[k] != 0 && cc[k] == i && cv[k] == mc[i])
				case (ca[k])
					1: if (!md[i]) mt[ct[k]] = 1;
					2: if (md[i]) mt[ct[k]] = 0;
					3: if (!dis[im[i]]) ex[im[i]] = 1;
				endcase
		chk("irq", ex, seen);
		chk("tgt", mt, compare_target_bit);
		repeat (1000) @(posedge clk);
	endtask
	initial
	begin
		repeat (20) @(posedge clk);
		rst_n <= 1;
		@(posedge clk);
		rd(hscmp_pkg::OFF_STAT);
		chk("stat", 0, rv);
		rd(12'hFFC);
		chk("resp", hscmp_pkg::RESP_ERR, rs);
		x = xs();
		wr(hscmp_pkg::OFF_TGT, x);
		chk("bresp", hscmp_pkg::RESP_OK, rs);
		chk("tgt", x[7:0], compare_target_bit);
		rd(hscmp_pkg::OFF_STAT);
		chk("stat", {x[7:0], 8'h00}, rv);
		wr(hscmp_pkg::OFF_TGT, 0);
		$display("registers done");
		sw_cfg(0, 1, 3, 0, 100);
		sw_cfg(1, 2, 3, 0, 100);
		sw_cfg(2, 3, 0, 0, 1);
		wr(hscmp_pkg::OFF_SWCNT + 12'hC, 100);
		repeat (5) @(posedge clk);
		chk("tgt", mt, compare_target_bit);
		wr(hscmp_pkg::OFF_SWCNT + 12'hC, 99);
		mc[3] = 99;
		pulse(3);
		pulse(3);
		wr(hscmp_pkg::OFF_DIR, 32'h8);
		md[3] = 1;
		pulse(3);
		pulse(0);
		wr(hscmp_pkg::OFF_IRQDIS, 1);
		dis = 1;
		sw_cfg(2, 3, 0, 0, 2);
		pulse(0);
		$display("software compare done");
		wr(hscmp_pkg::OFF_MODE, 2);
		wr(hscmp_pkg::OFF_ASSIGN, 32'hFB);
		wr(hscmp_pkg::OFF_HWCCFG + 12'h10, 32'h3ED);
		repeat (3) @(posedge clk);
		chk("err", 1, cfg_error);
		wr(hscmp_pkg::OFF_HWCCFG + 12'h10, 0);
		repeat (3) @(posedge clk);
		chk("err", 0, cfg_error);
		wr(hscmp_pkg::OFF_HWCCFG, 32'h7ED);
		wr(hscmp_pkg::OFF_HWCVAL, 4);
		for (int q = 1; q < 3; q++)
		begin
			qreq <= 1;
			@(posedge clk);
			qreq <= 0;
			repeat (40) @(posedge clk);
			rd(hscmp_pkg::OFF_HWCNT);
			chk("hwcnt", 4 * q, rv);
			mt[1] = q == 2;
			chk("tgt", mt, compare_target_bit);
		end
		$display("hardware compare done");
		end_sim();
	end
endmodule // tb_hs_counter_compare_unit
`default_nettype wire
